// ### rtl/ashi_pkg.sv
// ==========================================================
// serial host interface constants
package ashi_pkg;

	// ==========================================================
	// transfer lengths in serial clocks
	localparam logic [4:0] ASHI_CMD_LEN = 5'h08; // command byte
	localparam logic [4:0] ASHI_MAIN_LEN = 5'h18; // main result word
	localparam logic [4:0] ASHI_AUX_LEN = 5'h10; // aux result word
	localparam logic [4:0] ASHI_REG_LEN = 5'h08; // status and plain registers

	// ==========================================================
	// command byte layout
	localparam int ASHI_CMD_READ_BIT = 6; // 1 = read, 0 = write
	localparam int ASHI_ADDR_W = 4; // address field width, bits 3:0
	localparam int ASHI_REG_W = 8; // width of a stored register

	// ==========================================================
	// register addresses
	localparam logic [3:0] ASHI_ADDR_STATUS = 4'h0; // ready flags
	localparam logic [3:0] ASHI_ADDR_MAIN = 4'h4; // main result
	localparam logic [3:0] ASHI_ADDR_AUX = 4'h5; // aux result

	// ==========================================================
	// status field positions and reset values
	localparam int ASHI_STAT_MAIN_BIT = 0; // main result flag
	localparam int ASHI_STAT_AUX_BIT = 1; // aux result flag
	localparam logic [7:0] ASHI_REG_DEFAULT = 8'h00; // power-on register value

	// ==========================================================
	// run of ones that resets the interface
	localparam int ASHI_ONES_RUN = 32;

	// ==========================================================
	// link phase: what the next bits belong to
	typedef enum logic [1:0] {
		ASHI_CMD, // awaiting command byte
		ASHI_WR, // shifting in a register value
		ASHI_RD // shifting out a register value
	} ashi_phase_e;

endpackage : ashi_pkg

// ### rtl/ashi_regmem.sv
// ==========================================================
// small register store, registered read port
module ashi_regmem
	import ashi_pkg::*;
#(
	parameter int AW = 4, // address width
	parameter int DW = 8, // data width
	parameter logic [DW-1:0] DEF = '0 // power-on word value
) (
	input wire logic clk, // link clock
	input wire logic rst_n, // async reset, active low
	input wire logic clr, // sync restore of all words
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write address
	input wire logic [DW-1:0] wdata, // write data
	input wire logic re, // read strobe
	input wire logic [AW-1:0] raddr, // read address
	output logic [DW-1:0] rdata_ff // registered read data
);

	logic [DW-1:0] mem_ff [2**AW]; // word store

	// ==========================================================
	// word storage, restored by reset or clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_ff[i] <= DEF; // power-on value
			end
		end else if (clr) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_ff[i] <= DEF; // restore every word
			end
		end else if (we) begin
			mem_ff[waddr] <= wdata; // store one word
		end
	end

	// ==========================================================
	// registered read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= DEF;
		end else if (re) begin
			rdata_ff <= mem_ff[raddr];
		end
	end

endmodule : ashi_regmem

// ### rtl/ashi_serial_if.sv
// Operation
// - after reset, next byte is command
// - command selects direction and target register
// - write: command, then new register contents
// - read: command, then chosen register out
// - data in on din, out dout, sclk-timed
// - ready low when any result loads
// - ready high after the last unread result has been read
// - ready high shortly before result update
// - select low gates device onto bus; here dout is driven at every select level
// - same result may be read again
// - select tied low: flags via status
// - frame mode: msb out before clocking
// - transfers do not advance while select high
// - reset input restores interface state
// - 32 ones on din reset interface
// - after ones reset, await command
// - ones reset restores registers to defaults
// - falling edge of sclk updates output
// - ready high once no result unread, or update near
module ashi_serial_if
	import ashi_pkg::*;
#(
	parameter int ONES_RUN = ASHI_ONES_RUN // ones that reset the link
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic clk_en, // freezes system-side state when low
	input wire logic sclk, // serial clock from host
	input wire logic cs_n, // select, active low
	input wire logic din, // serial data in
	output logic dout, // serial data out
	output logic rdy_n, // data ready, active low
	input wire logic main_load, // pulse: new main result
	input wire logic [23:0] main_word, // main result value
	input wire logic aux_load, // pulse: new aux result
	input wire logic [15:0] aux_word, // aux result value
	input wire logic upd_soon // pulse: result update is near
);

	// ==========================================================
	// elaboration check
	if (ONES_RUN < 2 || ONES_RUN > 63) begin : g_bad_run
		$error("ones run length out of range");
	end

	localparam logic [5:0] ONES_LAST = 6'(ONES_RUN - 1); // last count before reset

	// ==========================================================
	// decoding shared by several processes
	function automatic logic [4:0] xfer_len(ashi_phase_e ph, logic [3:0] a);
		logic [4:0] n;
		n = ASHI_REG_LEN;
		if (ph == ASHI_CMD) begin
			n = ASHI_CMD_LEN; // command byte
		end else if (a == ASHI_ADDR_MAIN) begin
			n = ASHI_MAIN_LEN; // main result
		end else if (a == ASHI_ADDR_AUX) begin
			n = ASHI_AUX_LEN; // aux result
		end
		return n;
	endfunction : xfer_len

	// address backed by the register store
	function automatic logic is_store(logic [3:0] a);
		return a != ASHI_ADDR_STATUS && a != ASHI_ADDR_MAIN && a != ASHI_ADDR_AUX;
	endfunction : is_store

	// ==========================================================
	// system-side declarations
	logic rst_s1_ff; // reset release, first stage
	logic rst_n_ff; // synchronised reset, used everywhere
	logic [2:0] tgl_s1_ff; // toggle sync, first stage
	logic [2:0] tgl_s2_ff; // toggle sync, second stage
	logic [2:0] tgl_prev_ff; // toggle sync, edge memory
	logic [2:0] evt; // {ones reset, aux read, main read} pulses
	logic main_flag_ff; // main result unread
	logic aux_flag_ff; // aux result unread
	logic blank_ff; // update imminent, ready forced high
	logic rdy_n_ff; // ready output register
	logic [23:0] main_data_ff; // held main result
	logic [15:0] aux_data_ff; // held aux result
	logic nxt_main_flag; // next main flag
	logic nxt_aux_flag; // next aux flag
	logic nxt_blank; // next blanking state

	// ==========================================================
	// link-side declarations
	logic lrst_n; // link reset, from the synchronised copy
	ashi_phase_e phase_ff; // current transfer phase
	logic [4:0] cnt_ff; // bits done in this transfer
	logic [6:0] sr_ff; // input shift register
	logic [7:0] cmd_ff; // last command byte
	logic [5:0] ones_ff; // consecutive ones seen
	logic [1:0] stat_s1_ff; // flag sync, first stage
	logic [1:0] stat_s2_ff; // flag sync, second stage
	logic [7:0] stat_snap_ff; // status frozen at command end
	logic main_rd_tgl_ff; // flips when main result read
	logic aux_rd_tgl_ff; // flips when aux result read
	logic ones_tgl_ff; // flips on ones reset
	logic dout_ff; // output bit, falling edge
	logic [7:0] cmd_in; // byte including current bit
	logic ones_hit; // this edge completes the run of ones
	logic last; // this edge ends the transfer
	logic [7:0] mem_q; // stored register read data
	logic [23:0] src_word; // word being read out
	logic [4:0] bit_idx; // index of the next output bit
	logic out_bit; // next output bit
	logic mem_we; // register store write
	logic mem_re; // register store read
	logic ones_clr; // register store restore

	// ==========================================================
	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// link reset follows the system reset copy
	assign lrst_n = rst_n_ff;

	// ==========================================================
	// link events into the system domain
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tgl_s1_ff <= 3'h0;
			tgl_s2_ff <= 3'h0;
			tgl_prev_ff <= 3'h0;
		end else if (clk_en) begin
			tgl_s1_ff <= {ones_tgl_ff, aux_rd_tgl_ff, main_rd_tgl_ff};
			tgl_s2_ff <= tgl_s1_ff;
			tgl_prev_ff <= tgl_s2_ff;
		end
	end

	// one pulse per toggle
	assign evt = tgl_s2_ff ^ tgl_prev_ff;

	// ==========================================================
	// result flags: a load wins over a read clear
	assign nxt_main_flag = main_load | (main_flag_ff & ~evt[0] & ~evt[2]);
	assign nxt_aux_flag = aux_load | (aux_flag_ff & ~evt[1] & ~evt[2]);
	// blanking from update warning until the update lands or a ones reset
	assign nxt_blank = ~(main_load | aux_load) & (upd_soon | blank_ff) & ~evt[2];

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			main_flag_ff <= 1'b0;
			aux_flag_ff <= 1'b0;
			blank_ff <= 1'b0;
		end else if (clk_en) begin
			main_flag_ff <= nxt_main_flag;
			aux_flag_ff <= nxt_aux_flag;
			blank_ff <= nxt_blank;
		end
	end

	// ==========================================================
	// ready low while any result unread and no update near
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdy_n_ff <= 1'b1;
		end else if (clk_en) begin
			rdy_n_ff <= ~((nxt_main_flag | nxt_aux_flag) & ~nxt_blank);
		end
	end

	assign rdy_n = rdy_n_ff;

	// ==========================================================
	// result words, kept until replaced or cleared by a ones reset; reread is allowed
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			main_data_ff <= 24'h000000;
			aux_data_ff <= 16'h0000;
		end else if (clk_en) begin
			if (main_load) begin
				main_data_ff <= main_word;
			end else if (evt[2]) begin
				main_data_ff <= 24'h000000;
			end
			if (aux_load) begin
				aux_data_ff <= aux_word;
			end else if (evt[2]) begin
				aux_data_ff <= 16'h0000;
			end
		end
	end

	// ==========================================================
	// link decode helpers
	assign cmd_in = {sr_ff, din};
	assign ones_hit = din && (ones_ff == ONES_LAST);
	assign last = (cnt_ff == xfer_len(phase_ff, cmd_ff[3:0]) - 5'h01);

	// ==========================================================
	// run-of-ones counter, only while selected
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			ones_ff <= 6'h00;
		end else if (!cs_n) begin
			if (ones_hit || !din) begin
				ones_ff <= 6'h00;
			end else begin
				ones_ff <= ones_ff + 6'h01;
			end
		end
	end

	// ==========================================================
	// bit counter and phase, sampled on the rising edge
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			phase_ff <= ASHI_CMD;
			cnt_ff <= 5'h00;
			cmd_ff <= 8'h00;
		end else if (!cs_n) begin
			if (ones_hit) begin
				phase_ff <= ASHI_CMD;
				cnt_ff <= 5'h00;
			end else if (last) begin
				cnt_ff <= 5'h00;
				unique case (phase_ff)
					ASHI_CMD: begin
						cmd_ff <= cmd_in;
						phase_ff <= cmd_in[ASHI_CMD_READ_BIT] ? ASHI_RD : ASHI_WR;
					end
					ASHI_WR, ASHI_RD: begin
						phase_ff <= ASHI_CMD;
					end
					default: begin
						phase_ff <= ASHI_CMD; // illegal code recovers
					end
				endcase
			end else begin
				cnt_ff <= cnt_ff + 5'h01;
			end
		end
	end

	// ==========================================================
	// input shift, msb arrives first
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			sr_ff <= 7'h00;
		end else if (!cs_n) begin
			sr_ff <= cmd_in[6:0];
		end
	end

	// ==========================================================
	// ready flags into the link domain
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			stat_s1_ff <= 2'h0;
			stat_s2_ff <= 2'h0;
		end else begin
			stat_s1_ff <= {aux_flag_ff, main_flag_ff};
			stat_s2_ff <= stat_s1_ff;
		end
	end

	// status frozen at command end so it cannot tear mid-read
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			stat_snap_ff <= 8'h00;
		end else if (!cs_n && phase_ff == ASHI_CMD && last) begin
			stat_snap_ff <= 8'h00;
			stat_snap_ff[ASHI_STAT_MAIN_BIT] <= stat_s2_ff[0];
			stat_snap_ff[ASHI_STAT_AUX_BIT] <= stat_s2_ff[1];
		end
	end

	// ==========================================================
	// read completion and ones reset toggles
	always_ff @(posedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			main_rd_tgl_ff <= 1'b0;
			aux_rd_tgl_ff <= 1'b0;
			ones_tgl_ff <= 1'b0;
		end else if (!cs_n) begin
			if (ones_hit) begin
				ones_tgl_ff <= ~ones_tgl_ff;
			end else if (last && phase_ff == ASHI_RD) begin
				if (cmd_ff[3:0] == ASHI_ADDR_MAIN) begin
					main_rd_tgl_ff <= ~main_rd_tgl_ff;
				end
				if (cmd_ff[3:0] == ASHI_ADDR_AUX) begin
					aux_rd_tgl_ff <= ~aux_rd_tgl_ff;
				end
			end
		end
	end

	// ==========================================================
	// register store access
	assign mem_we = !cs_n && !ones_hit && last && phase_ff == ASHI_WR
		&& is_store(cmd_ff[3:0]);
	assign mem_re = !cs_n && !ones_hit && last && phase_ff == ASHI_CMD;
	assign ones_clr = !cs_n && ones_hit;

	ashi_regmem #(
		.AW(ASHI_ADDR_W),
		.DW(ASHI_REG_W),
		.DEF(ASHI_REG_DEFAULT)
	) u_regmem (
		.clk(sclk),
		.rst_n(lrst_n),
		.clr(ones_clr),
		.we(mem_we),
		.waddr(cmd_ff[3:0]),
		.wdata(cmd_in),
		.re(mem_re),
		.raddr(cmd_in[3:0]),
		.rdata_ff(mem_q)
	);

	// ==========================================================
	// read source; results are held still by the ready protocol
	always_comb begin
		src_word = {16'h0000, mem_q};
		if (cmd_ff[3:0] == ASHI_ADDR_STATUS) begin
			src_word = {16'h0000, stat_snap_ff};
		end else if (cmd_ff[3:0] == ASHI_ADDR_MAIN) begin
			src_word = main_data_ff;
		end else if (cmd_ff[3:0] == ASHI_ADDR_AUX) begin
			src_word = {8'h00, aux_data_ff};
		end
	end

	// msb first: index counts down from the top bit
	assign bit_idx = xfer_len(ASHI_RD, cmd_ff[3:0]) - 5'h01 - cnt_ff;
	assign out_bit = src_word[bit_idx];

	// ==========================================================
	// output bit on the falling edge; runs with select high too,
	// so the msb already stands when a frame select falls
	always_ff @(negedge sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			dout_ff <= 1'b1;
		end else if (phase_ff == ASHI_RD) begin
			dout_ff <= out_bit;
		end else begin
			dout_ff <= 1'b1; // idle high
		end
	end

	assign dout = dout_ff;

	// ==========================================================
	// checks, system side
	rdy_on_load_a: assert property (
		@(posedge clk) disable iff (!rst_n_ff)
		(clk_en && (main_load || aux_load)) |=> !rdy_n)
		else $error("ready not low after result load");

	rdy_blank_a: assert property (
		@(posedge clk) disable iff (!rst_n_ff)
		(clk_en && upd_soon && !main_load && !aux_load)
		|=> rdy_n ##1 (rdy_n || $past(clk_en && (main_load || aux_load))))
		else $error("ready not high before update");

	rdy_both_read_a: assert property (
		@(posedge clk) disable iff (!rst_n_ff)
		$rose(rdy_n) |-> ((!main_flag_ff && !aux_flag_ff) || blank_ff))
		else $error("ready rose with a result unread");

	main_read_clear_a: assert property (
		@(posedge clk) disable iff (!rst_n_ff)
		(clk_en && evt[0] && !main_load) |=> !main_flag_ff)
		else $error("main flag survived its read");

	// ==========================================================
	// checks, link side
	ones_reset_a: assert property (
		@(posedge sclk) disable iff (!lrst_n)
		(!cs_n && ones_hit) |=> (phase_ff == ASHI_CMD && cnt_ff == 5'h00))
		else $error("ones run did not reset the link");

	cmd_decode_a: assert property (
		@(posedge sclk) disable iff (!lrst_n)
		(!cs_n && !ones_hit && phase_ff == ASHI_CMD && cnt_ff == ASHI_CMD_LEN - 5'h01)
		|=> (phase_ff == ($past(sr_ff[ASHI_CMD_READ_BIT - 1]) ? ASHI_RD : ASHI_WR)
		&& cmd_ff[3:0] == $past({sr_ff[2:0], din})))
		else $error("command byte direction misdecoded");

	cs_ignore_a: assert property (
		@(posedge sclk) disable iff (!lrst_n)
		cs_n |=> ($stable(phase_ff) && $stable(cnt_ff) && $stable(ones_ff)))
		else $error("link moved while deselected");

	msb_first_a: assert property (
		@(negedge sclk) disable iff (!lrst_n)
		(phase_ff == ASHI_RD && cnt_ff == 5'h00
		&& (cmd_ff[3:0] == ASHI_ADDR_MAIN || cmd_ff[3:0] == ASHI_ADDR_AUX))
		|=> (dout_ff == $past(cmd_ff[3:0] == ASHI_ADDR_AUX
		? aux_data_ff[15] : main_data_ff[23])))
		else $error("first output bit not the word msb");

endmodule : ashi_serial_if

// ### verif/ashi_host_model.sv
// ==========================================================
// host serial port model: drives clock, select and data in
module ashi_host_model (
	output logic sclk, // serial clock, idles high between frames
	output logic cs_n, // select, active low
	output logic din, // serial data to the device
	input wire logic dout // serial data from the device
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int HALF = 32; // half of the 64 ns link period

	// idle: clock high, deselected
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// ==========================================================
	// one frame of n bits, msb first; fs = select used as frame sync
	task automatic frame(input bit fs, input int n, input logic [31:0] tx,
		output logic [31:0] rx);
		rx = '0;
		if (fs) begin // free-running clock while deselected
			repeat (3) begin
				sclk = 1'b0;
				din = ~din;
				#HALF;
				sclk = 1'b1;
				#HALF;
			end
			sclk = 1'b0; // select falls after the clock edge
			din = tx[n-1];
			#(HALF / 2);
			cs_n = 1'b0;
			#(HALF / 2);
		end else begin // plain select framing
			cs_n = 1'b0;
			#HALF;
		end
		for (int i = n - 1; i >= 0; i--) begin // msb first
			if (!(fs && i == n - 1)) begin // falling edge, new data
				sclk = 1'b0;
				din = tx[i];
				#HALF;
			end
			rx[i] = dout; // sampled just ahead of the rising edge
			sclk = 1'b1;
			#HALF;
		end
		cs_n = 1'b1;
		din = ~din; // released line no longer shows the last bit
		#HALF;
	endtask : frame

	// ==========================================================
	// park the clock at a level outside a frame
	task automatic drive_clk(input logic lvl);
		sclk = lvl;
	endtask : drive_clk

endmodule : ashi_host_model

// ### verif/tb_top.sv
// ==========================================================
// self-checking bench for the serial host interface
module tb_top
	import ashi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk; // system clock
	logic reset_n; // async reset, active low
	logic clk_en; // system-side enable
	logic main_load, aux_load, upd_soon; // result strobes
	logic [23:0] main_word; // main result value
	logic [15:0] aux_word; // aux result value
	logic sclk, cs_n, din, dout, rdy_n; // link pins
	int err_count, cmp_count; // mismatch and comparison counters
	logic [31:0] rx; // last received frame
	logic [23:0] w, w2, v; // scratch words
	logic [3:0] addrs [5] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'hf}; // plain registers

	ashi_serial_if #(.ONES_RUN(ASHI_ONES_RUN)) i_dut (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .rdy_n(rdy_n),
		.main_load(main_load), .main_word(main_word), .aux_load(aux_load),
		.aux_word(aux_word), .upd_soon(upd_soon));

	ashi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	// 100 MHz system clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// ==========================================================
	// expectations and compares
	function automatic logic [7:0] cmd_byte(input logic rd, input logic [3:0] a);
		cmd_byte = {4'h0, a};
		cmd_byte[ASHI_CMD_READ_BIT] = rd;
	endfunction : cmd_byte

	function automatic logic [23:0] stat_exp(input logic m, input logic a);
		stat_exp = {16'h0000, ASHI_REG_DEFAULT};
		stat_exp[ASHI_STAT_MAIN_BIT] = m;
		stat_exp[ASHI_STAT_AUX_BIT] = a;
	endfunction : stat_exp

	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
			err_count++;
		end
	endtask : chk_word

	task automatic chk_lvl(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
			err_count++;
		end
	endtask : chk_lvl

	// bounded wait for the ready level
	task automatic wait_rdy(input logic lvl);
		int k;
		k = 0;
		while (rdy_n !== lvl && k < 40) begin
			@(negedge clk);
			k++;
		end
		chk_lvl(rdy_n, lvl, "ready level");
		if (rdy_n !== lvl) results();
	endtask : wait_rdy

	// ==========================================================
	// link and result helpers
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		i_host.frame(1'b0, 8, {24'h0, cmd_byte(1'b0, a)}, rx);
		i_host.frame(1'b0, 8, {24'h0, d}, rx);
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input int n, input bit fs, output logic [23:0] d);
		i_host.frame(1'b0, 8, {24'h0, cmd_byte(1'b1, a)}, rx);
		i_host.frame(fs, n, 32'h0, rx);
		d = rx[23:0];
	endtask : reg_rd

	task automatic load(input bit aux, input logic [23:0] d);
		@(negedge clk);
		main_word = d;
		aux_word = d[15:0];
		main_load = !aux;
		aux_load = aux;
		@(negedge clk);
		main_load = 1'b0;
		aux_load = 1'b0;
	endtask : load

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// hang guard
	initial begin
		#400000;
		$display("[FAIL] %0t watchdog expired", $time);
		err_count++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		{main_load, aux_load, upd_soon} = 3'b000;
		main_word = '0;
		aux_word = '0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(89866));
		repeat (4) @(negedge clk);
		chk_lvl(rdy_n, 1'b1, "ready in reset");
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		reg_rd(ASHI_ADDR_STATUS, 8, 0, v);
		chk_word(v, stat_exp(0, 0), "status after reset");
		$display("test reset done");
		foreach (addrs[i]) begin // write then read back each of the five plain registers in addrs
			w = 24'($urandom) & 24'h0000ff;
			reg_wr(addrs[i], w[7:0]);
			reg_rd(addrs[i], 8, 0, v);
			chk_word(v, w, "register readback");
		end
		$display("test registers done");
		w = 24'($urandom);
		load(0, w);
		chk_lvl(rdy_n, 1'b0, "ready after main load");
		reg_rd(ASHI_ADDR_STATUS, 8, 0, v);
		chk_word(v, stat_exp(1, 0), "status main flag");
		reg_rd(ASHI_ADDR_MAIN, 24, 0, v);
		chk_word(v, w, "main result");
		wait_rdy(1'b1);
		reg_rd(ASHI_ADDR_MAIN, 24, 0, v);
		chk_word(v, w, "main result again");
		i_host.frame(1'b0, 8, {24'h0, cmd_byte(1'b0, ASHI_ADDR_MAIN)}, rx);
		i_host.frame(1'b0, 24, {8'h00, ~w}, rx);
		reg_rd(ASHI_ADDR_MAIN, 24, 0, v);
		chk_word(v, w, "main after refused write");
		$display("test main result done");
		w = 24'($urandom);
		w2 = 24'($urandom) & 24'h00ffff;
		load(0, w);
		load(1, w2);
		reg_rd(ASHI_ADDR_MAIN, 24, 0, v);
		chk_word(v, w, "main of pair");
		repeat (10) @(negedge clk);
		chk_lvl(rdy_n, 1'b0, "ready held for aux");
		reg_rd(ASHI_ADDR_AUX, 16, 0, v);
		chk_word(v, w2, "aux of pair");
		wait_rdy(1'b1);
		$display("test both results done");
		load(0, 24'($urandom));
		@(negedge clk);
		upd_soon = 1'b1;
		@(negedge clk);
		upd_soon = 1'b0;
		wait_rdy(1'b1);
		clk_en = 1'b0;
		load(0, 24'($urandom));
		repeat (3) @(negedge clk);
		chk_lvl(rdy_n, 1'b1, "load frozen");
		clk_en = 1'b1;
		$display("test update and enable done");
		w2 = 24'($urandom) & 24'h00ffff;
		load(1, w2);
		reg_rd(ASHI_ADDR_AUX, 16, 1, v);
		chk_word(v, w2, "frame sync aux read");
		$display("test frame sync done");
		reg_wr(4'h3, 8'h5a);
		load(0, 24'($urandom));
		i_host.frame(1'b0, 24, 32'h0, rx);
		i_host.frame(1'b0, 32, 32'hffffffff, rx);
		reg_rd(4'h3, 8, 0, v);
		chk_word(v, 24'h0, "register after ones");
		reg_rd(ASHI_ADDR_STATUS, 8, 0, v);
		chk_word(v, stat_exp(0, 0), "flags after ones");
		wait_rdy(1'b1);
		$display("test ones reset done");
		reg_wr(4'h2, 8'h5a);
		load(0, 24'($urandom));
		i_host.frame(1'b0, 8, {24'h0, cmd_byte(1'b1, 4'h2)}, rx);
		i_host.drive_clk(1'b0);
		@(negedge clk);
		chk_lvl(dout, 1'b0, "msb before mid reset");
		reset_n = 1'b0;
		@(negedge clk);
		chk_lvl(rdy_n, 1'b1, "ready in mid reset");
		chk_lvl(dout, 1'b1, "dout in mid reset");
		i_host.drive_clk(1'b1);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		reg_rd(4'h2, 8, 0, v);
		chk_word(v, 24'h0, "register after reset");
		$display("test mid reset done");
		results();
	end

endmodule : tb_top
